// ### logic/dst_pkg.sv
package dst_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SAMPLE_MHZ = 27;
  localparam int unsigned LINE_CLOCKS = 864;
  localparam int unsigned NOSYNC_HOLD_LINES = 2040;
  localparam int unsigned XTAL_EXIT_CYCLES = 32;
  localparam int unsigned LLC_EXIT_CYCLES = 42;
  localparam int unsigned HD_DUTY_PCT = 45;
  localparam int unsigned HD_HIGH_CLOCKS = (LINE_CLOCKS * HD_DUTY_PCT) / 100;
  localparam logic [6:0] SMP_STEP = 7'(SAMPLE_MHZ);
  localparam logic [6:0] SMP_MOD = 7'(CLK_MHZ);

  // ==========================================================================
  // Loop and vertical window
  // ==========================================================================
  localparam logic [31:0] NOM_BASE = 32'h1147AE14;
  localparam logic [31:0] NOM_STEP = 32'h00161E4F;
  localparam logic [4:0] NOM_CODE_RST = 5'h10;
  localparam logic [31:0] DTO_MASK_1F = 32'h7FFFFFFF;
  localparam logic [31:0] DTO_MASK_2F = 32'h3FFFFFFF;
  localparam int unsigned TRACK_PERMILLE = 45;
  localparam int unsigned PERMILLE_DEN = 1000;
  localparam logic [4:0] KP_TV = 5'h0A;
  localparam logic [4:0] KP_TAPE = 5'h0C;
  localparam logic [4:0] KI_TV = 5'h04;
  localparam logic [4:0] KI_TAPE = 5'h06;
  localparam logic [10:0] LOCK_TOL = 11'h004;
  localparam logic [3:0] LOCK_LINES = 4'h8;
  localparam logic [1:0] VCHECKS = 2'h3;
  localparam logic [2:0] VHYST = 3'h4;
  localparam logic [9:0] SELF_MIN_LINES = 10'h0C0;
  localparam logic [9:0] SELF_MAX_LINES = 10'h2A8;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PHASE = 8'h04;
  localparam logic [7:0] A_VWIN = 8'h08;
  localparam logic [7:0] A_WAVE = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam int unsigned ST_POR_BIT = 1;
  localparam logic [9:0] PHASE_RST = 10'h000;
  localparam logic [7:0] WAVE_BASE_RST = 8'h80;
  localparam logic [7:0] WAVE_GAIN_RST = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dst_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dst_wb_rsp_type;

  typedef enum logic [1:0] {PH_XTAL, PH_LINE, PH_RUN, PH_STANDBY_BIT} dst_phase_type;

  typedef struct packed {
    logic standby_bit;
    logic no_self_adapt;
    logic generator_mode;
    logic tape_source_filter;
    logic line_rate_bit;
    logic [4:0] nominal_increment;
  } dst_ctrl_type;

  typedef struct packed {
    dst_ctrl_type ctrl;
    logic [9:0] phase_adj;
    logic [9:0] vmin;
    logic [9:0] vmax;
    logic [7:0] wave_base;
    logic [7:0] wave_gain;
    dst_phase_type ph;
    logic [5:0] rcnt;
    logic warm;
    logic power_on_flag;
    logic [6:0] smp_acc;
    logic [31:0] timing_oscillator;
    logic [31:0] inc;
    logic signed [19:0] integ;
    logic ext_prev;
    logic [9:0] pix;
    logic [5:0] sync_hi;
    logic [5:0] sync_lo;
    logic sync_lvl;
    logic [10:0] nosync;
    logic [3:0] lock_cnt;
    logic lock_flag;
    logic vs_prev;
    logic [10:0] vcnt;
    logic [10:0] vper;
    logic [1:0] vchk;
    logic [2:0] vmiss;
    logic vint;
    logic [15:0] prod;
    logic [9:0] dac;
    logic hd;
    logic [9:0] hd_cnt;
    logic llc_tick;
    logic int_hpulse;
    logic vsync_out;
    logic refs_en;
    dst_wb_rsp_type wb;
  } dst_state_type;

  function automatic dst_state_type dst_reset_state();
    dst_state_type s;
    s = '0;
    s.ctrl.nominal_increment = NOM_CODE_RST;
    s.phase_adj = PHASE_RST;
    s.vmin = SELF_MIN_LINES;
    s.vmax = SELF_MAX_LINES;
    s.wave_base = WAVE_BASE_RST;
    s.wave_gain = WAVE_GAIN_RST;
    s.ph = PH_XTAL;
    s.power_on_flag = 1'b1;
    s.inc = NOM_BASE;
    s.sync_hi = 6'h20;
    s.sync_lo = 6'h20;
    s.refs_en = 1'b1;
    return s;
  endfunction

endpackage

// ### logic/dst_core.sv
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/10ps
// Functional notes
// - Line clock locks to horizontal sync with exactly 864 clocks per line.
// - Sync sampled as 6-bit values at 27 MHz; high, low, threshold derived.
// - PI filter turns phase error into increment; tape or broadcast gains.
// - Five-bit field sets nominal oscillator frequency.
// - Generator mode runs loop open at nominal increment only.
// - Oscillator rate follows increment; multiplied by 2 or 4 per line rate.
// - Without sync, hold frequency 2040 lines, then return to nominal.
// - Readable lock flag reports loop lock.
// - Internal horizontal pulse phase programmable across one whole line.
// - Vertical sync accepted after minimum lines; artificial one after maximum.
// - Stored field length drives internal flywheel after consistency checks.
// - Mismatch reverts to external vertical sync after field hysteresis.
// - Pipelined processor computes output value from controls and beam current.
// - Full reset: line drive low, bus off, registers default, processor idle.
// - Full reset sets power-on flag; standby keeps it.
// - Standby: drive active, bus ready, scan registers reset, control kept.
// - Leave full reset after 32 crystal plus 42 line clocks; standby 42.
// - Self-adapt accepts 192 to 680 lines per field when enabled.
// - Loop tracks line rates within 4.5 percent of nominal.
// - Rate pin selects 1F/2F unless source select hands choice to register.
module dst_core #(
  parameter int unsigned LINE_CLOCKS = dst_pkg::LINE_CLOCKS,
  parameter int unsigned NOSYNC_HOLD_LINES = dst_pkg::NOSYNC_HOLD_LINES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dst_pkg::dst_wb_req_type wb_req_i,
  output dst_pkg::dst_wb_rsp_type wb_rsp_o,
  input wire logic reset_pin_n_i,
  input wire logic [5:0] sync_sample_i,
  input wire logic vsync_i,
  input wire logic ext_clock_select_i,
  input wire logic ext_clock_in_i,
  input wire logic line_rate_pin_i,
  input wire logic line_rate_source_sel_i,
  input wire logic [7:0] beam_current_i,
  output logic line_locked_clock_o,
  output logic int_hpulse_o,
  output logic line_drive_out_o,
  output logic vsync_out_o,
  output logic lock_flag_o,
  output logic refs_enable_o,
  output logic [9:0] dac_o
);
  import dst_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (LINE_CLOCKS < 16 || LINE_CLOCKS > 1024) begin : g_chk_line
    $error("LINE_CLOCKS must fit the 10-bit line position counter");
  end
  if (NOSYNC_HOLD_LINES < 2 || NOSYNC_HOLD_LINES > 2047) begin : g_chk_hold
    $error("NOSYNC_HOLD_LINES must fit the 11-bit loss counter");
  end

  localparam logic [9:0] PIX_LAST = 10'(LINE_CLOCKS - 1);
  localparam logic [9:0] PIX_HALF = 10'(LINE_CLOCKS / 2);
  localparam logic [10:0] PIX_SPAN = 11'(LINE_CLOCKS);
  localparam logic [10:0] HOLD_LAST = 11'(NOSYNC_HOLD_LINES - 1);
  localparam logic [10:0] HOLD_DONE = 11'(NOSYNC_HOLD_LINES);
  localparam logic [5:0] XTAL_LAST = 6'(XTAL_EXIT_CYCLES - 1);
  localparam logic [5:0] LLC_LAST = 6'(LLC_EXIT_CYCLES - 1);
  localparam logic [9:0] HD_LAST = 10'(HD_HIGH_CLOCKS - 1);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] nom_inc(input logic [4:0] code);
    logic signed [33:0] t;
    t = $signed({29'h0, code}) - $signed({29'h0, NOM_CODE_RST});
    return 32'($signed({2'h0, NOM_BASE}) + t * $signed({2'h0, NOM_STEP}));
  endfunction

  // Carry out of the masked field gives 2 or 4 line clocks per oscillator period
  function automatic logic dto_carry(input logic [31:0] acc, input logic [31:0] inc,
                                     input logic rate2);
    logic [31:0] m;
    logic [32:0] s;
    m = rate2 ? DTO_MASK_2F : DTO_MASK_1F;
    s = {1'b0, acc & m} + {1'b0, inc & m};
    return rate2 ? s[30] : s[31];
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  dst_state_type q;
  dst_state_type d;

  logic rate2;
  logic ext_mode;
  logic tick;
  logic line_start;
  logic s_en;
  logic new_lvl;
  logic sync_rise;
  logic vs_rise;
  logic ext_ev;
  logic bus_ok;
  logic drive_ok;
  logic [5:0] thr;
  logic [31:0] nom;
  logic [9:0] vmin_eff;
  logic [9:0] vmax_eff;
  logic signed [10:0] err;
  logic signed [20:0] isum;
  logic signed [19:0] integ_n;
  logic signed [33:0] corr;
  logic signed [33:0] lim;
  logic [4:0] kp;
  logic [4:0] ki;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [10:0] dac_raw;

  always_comb begin
    d = q;
    rate2 = line_rate_source_sel_i ? q.ctrl.line_rate_bit : line_rate_pin_i;
    ext_mode = ext_clock_select_i;
    nom = nom_inc(q.ctrl.nominal_increment);
    thr = 6'((7'(q.sync_hi) + 7'(q.sync_lo)) >> 1);
    vmin_eff = q.ctrl.no_self_adapt ? q.vmin : SELF_MIN_LINES;
    vmax_eff = q.ctrl.no_self_adapt ? q.vmax : SELF_MAX_LINES;
    kp = q.ctrl.tape_source_filter ? KP_TAPE : KP_TV;
    ki = q.ctrl.tape_source_filter ? KI_TAPE : KI_TV;
    bus_ok = (q.ph == PH_RUN) || (q.ph == PH_STANDBY_BIT) || q.warm;
    drive_ok = bus_ok;
    rd_val = 32'h0;
    wmask = lane_mask(wb_req_i.sel);
    wval = 32'h0;
    err = '0;
    isum = '0;
    integ_n = q.integ;
    corr = '0;
    lim = $signed(34'((64'(nom) * 64'(TRACK_PERMILLE)) / 64'(PERMILLE_DEN)));
    dac_raw = '0;
    d.llc_tick = 1'b0;
    d.int_hpulse = 1'b0;
    d.vsync_out = 1'b0;
    d.wb.ack = 1'b0;

    // ========================================================================
    // Oscillator and line position
    // ========================================================================
    d.ext_prev = ext_clock_in_i;
    d.timing_oscillator = q.timing_oscillator + q.inc;
    tick = ext_mode ? (ext_clock_in_i & ~q.ext_prev) : dto_carry(q.timing_oscillator, q.inc, rate2);
    line_start = tick && (q.pix == PIX_LAST);
    if (tick) begin
      d.llc_tick = 1'b1;
      d.pix = line_start ? 10'h000 : q.pix + 10'h001;
      d.int_hpulse = (q.pix == q.phase_adj);
    end

    // ========================================================================
    // Sync slicer
    // ========================================================================
    s_en = (q.smp_acc + SMP_STEP) >= SMP_MOD;
    d.smp_acc = s_en ? q.smp_acc + SMP_STEP - SMP_MOD : q.smp_acc + SMP_STEP;
    new_lvl = q.sync_lvl;
    if (s_en) begin
      new_lvl = ext_mode ? sync_sample_i[5] : (sync_sample_i > thr);
      if (sync_sample_i > q.sync_hi) begin
        d.sync_hi = sync_sample_i;
      end
      if (sync_sample_i < q.sync_lo) begin
        d.sync_lo = sync_sample_i;
      end
    end
    // Slow leak lets the levels follow a falling signal amplitude
    if (line_start && (7'(q.sync_hi) > 7'(q.sync_lo) + 7'h02)) begin
      d.sync_hi = q.sync_hi - 6'h01;
      d.sync_lo = q.sync_lo + 6'h01;
    end
    d.sync_lvl = new_lvl;
    sync_rise = new_lvl && !q.sync_lvl;

    // ========================================================================
    // Loop filter
    // ========================================================================
    if (q.pix >= PIX_HALF) begin
      err = $signed(11'({1'b0, q.pix}) - PIX_SPAN);
    end else begin
      err = $signed(11'({1'b0, q.pix}));
    end
    if (q.ctrl.generator_mode) begin
      d.integ = '0;
      d.inc = nom;
      d.nosync = '0;
      d.lock_cnt = '0;
      d.lock_flag = 1'b0;
    end else if (sync_rise) begin
      isum = 21'(q.integ) + 21'(err);
      if (isum > 21'sh07FFFF) begin
        integ_n = 20'sh7FFFF;
      end else if (isum < -21'sh080000) begin
        integ_n = -20'sh80000;
      end else begin
        integ_n = 20'(isum);
      end
      corr = (34'(err) <<< kp) + (34'(integ_n) <<< ki);
      if (corr > lim) begin
        corr = lim;
      end else if (corr < -lim) begin
        corr = -lim;
      end
      d.integ = integ_n;
      d.inc = 32'($signed({2'h0, nom}) - corr);
      d.nosync = '0;
      if ((err <= $signed(LOCK_TOL)) && (err >= -$signed(LOCK_TOL))) begin
        d.lock_cnt = (q.lock_cnt == LOCK_LINES) ? q.lock_cnt : q.lock_cnt + 4'h1;
        d.lock_flag = (q.lock_cnt >= LOCK_LINES - 4'h1);
      end else begin
        d.lock_cnt = '0;
        d.lock_flag = 1'b0;
      end
    end else if (line_start) begin
      if (q.nosync == HOLD_LAST) begin
        d.nosync = HOLD_DONE;
        d.integ = '0;
        d.inc = nom;
        d.lock_cnt = '0;
        d.lock_flag = 1'b0;
      end else if (q.nosync < HOLD_DONE) begin
        d.nosync = q.nosync + 11'h001;
      end
    end
    // Once sync is lost for good, follow a changed nominal field at once
    if (!q.ctrl.generator_mode && !sync_rise && q.nosync == HOLD_DONE) begin
      d.inc = nom;
    end

    // ========================================================================
    // Vertical window and flywheel
    // ========================================================================
    d.vs_prev = vsync_i;
    vs_rise = vsync_i && !q.vs_prev;
    ext_ev = vs_rise && (q.vcnt >= 11'(vmin_eff));
    if (!q.vint) begin
      if (ext_ev) begin
        d.vsync_out = 1'b1;
        d.vcnt = '0;
        d.vper = q.vcnt;
        if (q.vcnt == q.vper) begin
          d.vchk = (q.vchk == VCHECKS - 2'h1) ? '0 : q.vchk + 2'h1;
          d.vint = (q.vchk == VCHECKS - 2'h1);
        end else begin
          d.vchk = '0;
        end
      end else if (line_start) begin
        if (q.vcnt + 11'h001 >= 11'(vmax_eff)) begin
          d.vsync_out = 1'b1;
          d.vcnt = '0;
          d.vchk = '0;
        end else begin
          d.vcnt = q.vcnt + 11'h001;
        end
      end
    end else begin
      if (line_start) begin
        if (q.vcnt + 11'h001 >= q.vper) begin
          d.vsync_out = 1'b1;
          d.vcnt = '0;
        end else begin
          d.vcnt = q.vcnt + 11'h001;
        end
      end
      if (vs_rise) begin
        if (q.vcnt == 11'h000) begin
          d.vmiss = '0;
        end else if (q.vmiss == VHYST - 3'h1) begin
          d.vmiss = '0;
          d.vint = 1'b0;
          d.vchk = '0;
        end else begin
          d.vmiss = q.vmiss + 3'h1;
        end
      end
    end

    // ========================================================================
    // Output processor
    // ========================================================================
    // Two stages: product, then offset and clamp; idle outside normal running
    if (q.ph == PH_RUN) begin
      d.prod = 16'(q.wave_gain) * 16'(beam_current_i);
      dac_raw = 11'({q.wave_base, 2'h0}) - 11'(q.prod[15:6]);
      d.dac = dac_raw[10] ? 10'h000 : dac_raw[9:0];
    end else begin
      d.prod = '0;
      d.dac = '0;
    end

    // ========================================================================
    // Line drive
    // ========================================================================
    if (!drive_ok) begin
      d.hd = 1'b0;
      d.hd_cnt = '0;
    end else if (tick && (q.pix == q.phase_adj)) begin
      d.hd = 1'b1;
      d.hd_cnt = '0;
    end else if (tick && q.hd) begin
      d.hd_cnt = q.hd_cnt + 10'h001;
      d.hd = (q.hd_cnt != HD_LAST);
    end

    // ========================================================================
    // Register bus
    // ========================================================================
    case (wb_req_i.adr)
      A_CTRL: rd_val = {22'h0, q.ctrl};
      A_PHASE: rd_val = {22'h0, q.phase_adj};
      A_VWIN: rd_val = {6'h0, q.vmax, 6'h0, q.vmin};
      A_WAVE: rd_val = {16'h0, q.wave_gain, q.wave_base};
      A_STATUS: rd_val = {5'h0, q.vper, 11'h0, rate2, ext_mode, q.vint,
                          q.power_on_flag, q.lock_flag};
      default: rd_val = 32'h0;
    endcase
    wval = (rd_val & ~wmask) | (wb_req_i.dat & wmask);
    if (wb_req_i.cyc && wb_req_i.stb && !q.wb.ack && bus_ok) begin
      d.wb.ack = 1'b1;
      d.wb.dat = wb_req_i.we ? 32'h0 : rd_val;
      if (wb_req_i.we) begin
        case (wb_req_i.adr)
          A_CTRL: d.ctrl = dst_ctrl_type'(wval[9:0]);
          A_PHASE: d.phase_adj = wval[9:0];
          A_VWIN: begin
            d.vmin = wval[9:0];
            d.vmax = wval[25:16];
          end
          A_WAVE: begin
            d.wave_base = wval[7:0];
            d.wave_gain = wval[15:8];
          end
          A_STATUS: begin
            if (wb_req_i.dat[ST_POR_BIT] && wmask[ST_POR_BIT]) begin
              d.power_on_flag = 1'b0;
            end
          end
          default: d.wb.dat = 32'h0;
        endcase
      end
    end else if (!bus_ok) begin
      d.wb.dat = 32'h0;
    end

    // ========================================================================
    // Reset and standby sequencing
    // ========================================================================
    case (q.ph)
      PH_XTAL: begin
        d.rcnt = q.rcnt + 6'h01;
        if (q.rcnt == XTAL_LAST) begin
          d.ph = PH_LINE;
          d.rcnt = '0;
        end
      end
      PH_LINE: begin
        if (tick) begin
          d.rcnt = q.rcnt + 6'h01;
          if (q.rcnt == LLC_LAST) begin
            d.ph = PH_RUN;
            d.rcnt = '0;
            d.warm = 1'b0;
          end
        end
      end
      PH_RUN: begin
        if (q.ctrl.standby_bit) begin
          d.ph = PH_STANDBY_BIT;
          d.warm = 1'b1;
        end
      end
      PH_STANDBY_BIT: begin
        if (!q.ctrl.standby_bit) begin
          d.ph = PH_LINE;
          d.rcnt = '0;
        end
      end
      default: d.ph = PH_XTAL;
    endcase
    // Held at default for all of standby, so writes there do not stick
    if (d.ph == PH_STANDBY_BIT) begin
      d.phase_adj = PHASE_RST;
      d.vmin = SELF_MIN_LINES;
      d.vmax = SELF_MAX_LINES;
      d.wave_base = WAVE_BASE_RST;
      d.wave_gain = WAVE_GAIN_RST;
    end
    d.refs_en = (d.ph != PH_STANDBY_BIT);

    // Pin reset acts like power-on: full default, flag set, bus silent
    if (!reset_pin_n_i) begin
      d = dst_reset_state();
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= dst_reset_state();
    end else begin
      q <= d;
    end
  end

  assign wb_rsp_o = q.wb;
  assign line_locked_clock_o = q.llc_tick;
  assign int_hpulse_o = q.int_hpulse;
  assign line_drive_out_o = q.hd;
  assign vsync_out_o = q.vsync_out;
  assign lock_flag_o = q.lock_flag;
  assign refs_enable_o = q.refs_en;
  assign dac_o = q.dac;

endmodule

// ### tb/dst_props.sv
`timescale 1ns/10ps
// ====
// Checker
module dst_props #(
  parameter int unsigned LINE_CLOCKS = 864
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dst_pkg::dst_wb_req_type wb_req_i,
  input wire dst_pkg::dst_wb_rsp_type wb_rsp_o,
  input wire logic reset_pin_n_i,
  input wire logic ext_clock_select_i,
  input wire logic line_locked_clock_o,
  input wire logic int_hpulse_o,
  input wire logic line_drive_out_o,
  input wire logic vsync_out_o,
  input wire logic lock_flag_o,
  input wire logic refs_enable_o,
  input wire logic [9:0] dac_o
);
  import dst_pkg::*;
  logic [5:0] rel_q;
  logic [5:0] llcn_q;
  logic [9:0] pos_q;
  logic [9:0] hdc_q;
  logic seen_q;
  wire full_rst = rst_i || !reset_pin_n_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (full_rst);
  // Line length only judged on ext clock, where no relock can jump the count
  always_ff @(posedge clk_i) begin
    if (full_rst) begin
      rel_q <= 6'h00;
      llcn_q <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      if (rel_q < 6'h20) rel_q <= rel_q + 6'h01;
      else if (line_locked_clock_o && llcn_q != 6'h3F) llcn_q <= llcn_q + 6'h01;
      if (int_hpulse_o) seen_q <= ext_clock_select_i;
      if ((wb_rsp_o.ack && wb_req_i.we) || !ext_clock_select_i) seen_q <= 1'b0;
    end
    if (int_hpulse_o) pos_q <= 10'h000;
    else if (line_locked_clock_o) pos_q <= pos_q + 10'h001;
    // Restart on the pulse, since a new phase can retrigger a high drive
    if (int_hpulse_o) hdc_q <= 10'h001;
    else if (!line_drive_out_o) hdc_q <= 10'h000;
    else if (line_locked_clock_o) hdc_q <= hdc_q + 10'h001;
  end
  a_drive_width: assert property ($fell(line_drive_out_o) |-> hdc_q == 10'(HD_HIGH_CLOCKS))
    else $error("line drive high time wrong");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !line_drive_out_o && !lock_flag_o && dac_o == 10'h000 && refs_enable_o)
    else $error("outputs active after reset");
  a_exit_wait: assert property (wb_rsp_o.ack |-> rel_q == 6'h20 && llcn_q >= 6'h2A)
    else $error("bus answered before reset exit");
  a_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_ack_drop: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_line_len: assert property (int_hpulse_o && seen_q |-> pos_q == 10'(LINE_CLOCKS - 1))
    else $error("line length wrong");
  a_drive_start: assert property ($rose(line_drive_out_o) |-> int_hpulse_o)
    else $error("line drive rose off the pulse");
  a_pulse_tick: assert property (int_hpulse_o |-> line_locked_clock_o)
    else $error("pulse off a line tick");
  a_vsync_single: assert property (vsync_out_o |=> !vsync_out_o)
    else $error("field pulse too long");
  c_ack: cover property (wb_rsp_o.ack);
  c_pulse: cover property (int_hpulse_o && seen_q);
  c_field: cover property (vsync_out_o);
endmodule

// ### tb/dst_src.sv
`timescale 1ns/10ps
// ====
// Sync source
module dst_src (
  input wire logic clk_i,
  output logic ext_clock_in_o,
  output logic [5:0] sync_sample_o,
  output logic vsync_o
);
  logic [1:0] div_q = 2'h0;
  logic [9:0] tick_q = 10'h000;
  logic line_q = 1'b0;
  initial ext_clock_in_o = 1'b0;
  initial sync_sample_o = 6'h04;
  initial vsync_o = 1'b0;
  // Clock at a quarter of clk, far from the two excluded line rates
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    ext_clock_in_o <= div_q[1];
    if (div_q == 2'h3) begin
      tick_q <= (tick_q == 10'h35F) ? 10'h000 : tick_q + 10'h001;
      if (tick_q == 10'h35F) line_q <= !line_q;
    end
    sync_sample_o <= (tick_q < 10'h040) ? 6'h3C : 6'h04;
    vsync_o <= !line_q && tick_q < 10'h080;
  end
endmodule

// ### tb/dst_core_test.sv
`timescale 1ns/10ps
// ====
// Bench
module dst_core_test;
  import dst_pkg::*;
  logic clk_i, rst_i = 1'b1, pin_n = 1'b1, ext_sel = 1'b1, rate_pin = 1'b1, rate_src = 1'b0;
  logic [7:0] beam = 8'h00;
  dst_wb_req_type req = '0;
  dst_wb_rsp_type rsp;
  wire ext_clk, vs, llc, hp, drive, vso, lock, refs;
  wire [5:0] smp;
  wire [9:0] dac;
  int fail_count = 0, checked = 0, cycles = 0, vs_seen = 0, d1, d2;
  logic [31:0] q;
  dst_core #(.NOSYNC_HOLD_LINES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .reset_pin_n_i(pin_n), .sync_sample_i(smp), .vsync_i(vs),
    .ext_clock_select_i(ext_sel), .ext_clock_in_i(ext_clk), .line_rate_pin_i(rate_pin),
    .line_rate_source_sel_i(rate_src), .beam_current_i(beam), .line_locked_clock_o(llc),
    .int_hpulse_o(hp), .line_drive_out_o(drive), .vsync_out_o(vso), .lock_flag_o(lock),
    .refs_enable_o(refs), .dac_o(dac));
  dst_src src (.clk_i(clk_i), .ext_clock_in_o(ext_clk), .sync_sample_o(smp), .vsync_o(vs));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    vs_seen += int'(vso === 1'b1);
    if (cycles == 90000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q & m);
  endtask
  // Counts line ticks up to and including the next internal pulse
  task automatic to_hp(output int d);
    d = 0;
    do begin
      @(posedge clk_i);
      d += int'(llc === 1'b1);
    end while (hp !== 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_STATUS, 32'h1E, 32'h1A);
    rd(A_CTRL, 32'h3FF, 32'h010);
    rd(A_PHASE, 32'h3FF, 32'h000);
    rd(A_VWIN, 32'h03FF03FF, 32'h02A800C0);
    rd(A_WAVE, 32'hFFFF, 32'h0080);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, A_STATUS, 32'h2);
    rd(A_STATUS, 32'h2, 32'h0);
    bus(1'b1, A_PHASE, 32'h155);
    rd(A_PHASE, 32'h3FF, 32'h155);
    bus(1'b1, A_CTRL, 32'h310);
    repeat (4) @(posedge clk_i);
    chk("refs", 32'h0, {31'h0, refs});
    chk("dac standby", 32'h0, {22'h0, dac});
    rd(A_PHASE, 32'h3FF, 32'h000);
    rd(A_CTRL, 32'h3FF, 32'h310);
    rd(A_STATUS, 32'h2, 32'h0);
    bus(1'b1, A_CTRL, 32'h110);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("drive", 32'h0, {31'h0, drive});
    pin_n <= 1'b1;
    rd(A_CTRL, 32'h3FF, 32'h010);
    rd(A_STATUS, 32'h2, 32'h2);
    for (int i = 0; i < 8; i++) begin
      rate_pin <= i[0];
      rate_src <= i[1];
      bus(1'b1, A_CTRL, 32'h110 | (32'(i[2]) << 5));
      rd(A_STATUS, 32'h10, (i[1] ? 32'(i[2]) : 32'(i[0])) << 4);
    end
    bus(1'b1, A_VWIN, 32'h00030001);
    bus(1'b1, A_WAVE, 32'h4080);
    to_hp(d1);
    to_hp(d1);
    chk("line", LINE_CLOCKS, d1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, A_PHASE, 32'(i) << 8);
      @(posedge smp[5]);
      to_hp(d2);
      if (i == 0) d1 = d2;
    end
    chk("phase", 32'h100, (d2 - d1 + LINE_CLOCKS) % LINE_CLOCKS);
    repeat (6) to_hp(d2);
    rd(A_STATUS, 32'h07FF0004, 32'h00020004);
    chk("field pulses", 32'h1, 32'(vs_seen > 0));
    for (int i = 0; i < 2; i++) begin
      beam <= i ? 8'hFF : 8'h00;
      repeat (8) @(posedge clk_i);
      chk("dac", i ? 32'h101 : 32'h200, {22'h0, dac});
    end
    ext_sel <= 1'b0;
    rate_src <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rate_pin <= i[0];
      bus(1'b1, A_CTRL, 32'h180 | (i ? 32'h1F : 32'h0));
      repeat (50) @(posedge clk_i);
      d1 = 0;
      repeat (2000) @(posedge clk_i) d1 += int'(llc === 1'b1);
      d2 = int'(((longint'(NOM_BASE) + (i ? 15 : -16) * longint'(NOM_STEP))
        * (i ? 8000 : 4000)) >> 32);
      if (d1 == d2 + 1 || d1 == d2 - 1) d1 = d2;
      chk("tick rate", d2, d1);
    end
    results();
  end
endmodule
bind dst_core dst_props #(.LINE_CLOCKS(LINE_CLOCKS)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .reset_pin_n_i(reset_pin_n_i),
  .ext_clock_select_i(ext_clock_select_i), .line_locked_clock_o(line_locked_clock_o),
  .int_hpulse_o(int_hpulse_o), .line_drive_out_o(line_drive_out_o),
  .vsync_out_o(vsync_out_o), .lock_flag_o(lock_flag_o), .refs_enable_o(refs_enable_o),
  .dac_o(dac_o));
